// ===== rtl/hidra_pkg.sv
// Constants and types of the host interface memory with its parameter RAM window.
// Assumes one 125 MHz clock and a Wishbone slave whose register index is byte address / 4.
package hidra_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int SAMPLE_HZ = 9600;
	// Longest spacing rounds down
	localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

	localparam logic [4:0] REG_PHASE_DET = 5'h02;
	localparam logic [4:0] REG_ASYNC_FMT = 5'h06;
	localparam logic [4:0] REG_LOOP_SIG = 5'h08;
	localparam logic [4:0] REG_LINE_STAT = 5'h0B;
	localparam logic [4:0] REG_TEST_STAT = 5'h0F;
	localparam logic [4:0] REG_PDATA_HIGH = 5'h18;
	localparam logic [4:0] REG_PDATA_LOW = 5'h19;
	localparam logic [4:0] REG_PADDR_LOW = 5'h1C;
	localparam logic [4:0] REG_PADDR_HIGH = 5'h1D;
	localparam logic [4:0] REG_PACCESS = 5'h1F;

	localparam int BIT_PREP_DET_EN = 0;
	localparam int BIT_ACK_DET_EN = 1;
	localparam int BIT_TERM_DET_EN = 2;
	localparam int BIT_PREP_SEND = 2;
	localparam int BIT_ACK_SEND = 3;
	localparam int BIT_TERM_SEND = 4;
	localparam int BIT_DISCONNECT = 1;
	localparam int BIT_PATTERN_DET = 0;
	localparam int BIT_ACC_REQ = 0;
	localparam int BIT_ACC_WRITE = 1;
	localparam int BIT_ACC_WORD = 2;
	localparam int BIT_ACC_HIGH = 3;
	localparam logic [7:0] PACCESS_MASK = 8'h0F;
	localparam logic [7:0] PADDR_HIGH_MASK = 8'h0F;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] SCRAMBLER_SEED = 7'h7F;
	localparam logic [3:0] CHAR_BITS_MIN = 4'h5;

	localparam logic [13:0] ACK_BITS = 14'd1948;
	localparam logic [13:0] PREP_BITS = 14'd2048;
	localparam logic [13:0] TERM_BITS = 14'd8192;
	localparam logic [13:0] TERM_TAIL_BITS = 14'd64;

	// Start of read-only diagnostic words; value is arbitrary
	localparam logic [11:0] DIAG_BASE_DEF = 12'hF00;

	typedef enum logic [1:0] {TX_IDLE, TX_SCRAMBLED, TX_TAIL} hidra_tx_state_t;
endpackage

// ===== rtl/hidra_top.sv
// Host interface memory: loopback signalling, line status, async format and
// the indirect window onto the 16-bit parameter RAM served once per sample period.
// Assumes receiver and transmitter status strobes come from logic on clk_i.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Contract
// - Disconnect flag when disconnected and self-locked
// - Acknowledge: 1948 scrambled ones at bit rate
// - Preparatory: 2048 scrambled zeros at bit rate
// - Termination: 8192 scrambled ones, 64 plain ones
// - Three bits enable the three phase detectors
// - One status bit shows any pattern detected
// - Two bits select 5 to 8 data bits
// - Registers 00 to 1F, eight bits each
// - 16-bit RAM, 12-bit address at 1C/1D
// - RAM data passes via high/low data registers
// - One transfer per sample period at 9600 Hz
// - Host sets request; polled every sample period
// - Eight-bit parameters use low register only
// - Byte-written words use low/high access codes
// - Full words read and written at once
// - Diagnostic words are read only
module hidra_top
	import hidra_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int RAM_ADDR_W = 12,
	parameter logic [11:0] DIAG_BASE = DIAG_BASE_DEF
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic line_disconnect_i,
	input wire logic own_signal_lock_i,
	input wire logic prep_pattern_seen_i,
	input wire logic ack_pattern_seen_i,
	input wire logic term_pattern_seen_i,
	input wire logic tx_bit_tick_i,
	output logic loop_tx_bit_o,
	output logic loop_tx_active_o,
	output logic loop_prep_detector_enable_o,
	output logic loop_ack_detector_enable_o,
	output logic loop_term_detector_enable_o,
	output logic [3:0] char_bits_o
);

	logic [7:0] phase_det_r;
	logic [7:0] async_fmt_r;
	logic [7:0] loop_sig_r;
	logic [7:0] loop_sig_prev_r;
	logic line_disconnect_detected_r;
	logic loop_pattern_detected_r;
	logic [7:0] param_data_high_r;
	logic [7:0] param_data_low_r;
	logic [7:0] param_addr_low_r;
	logic [7:0] param_addr_high_r;
	logic [7:0] paccess_r;
	logic [13:0] sample_cnt_r;
	logic sample_tick_r;
	logic read_pend_r;
	logic [15:0] ram_q_r;
	logic [15:0] ram_mem [0:(1 << RAM_ADDR_W) - 1];
	hidra_tx_state_t tx_state_r;
	logic [13:0] tx_cnt_r;
	logic [6:0] scr_r;
	logic tx_din_r;

	logic wb_req;
	logic wb_wr;
	logic [4:0] reg_idx;
	logic [7:0] rd_byte;
	logic [11:0] ram_addr;
	logic access_go;
	logic diag_word;
	logic scr_fb;
	logic [7:0] loop_rise;

	// Narrow registers, so one lane carries all data
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	assign reg_idx = wb_adr_i[6:2];
	assign ram_addr = {param_addr_high_r[3:0], param_addr_low_r};
	assign diag_word = ram_addr >= DIAG_BASE;
	assign access_go = sample_tick_r & paccess_r[BIT_ACC_REQ];
	assign scr_fb = tx_din_r ^ scr_r[3] ^ scr_r[6];
	assign loop_rise = loop_sig_r & ~loop_sig_prev_r;

	// Every index 00..1F answers; unassigned ones and upper address space read zero
	always_comb
	begin
		rd_byte = RESET_BYTE;
		if (wb_adr_i[7] == 1'b0)
		begin
			unique case (reg_idx)
				REG_PHASE_DET: rd_byte = phase_det_r;
				REG_ASYNC_FMT: rd_byte = async_fmt_r;
				REG_LOOP_SIG: rd_byte = loop_sig_r;
				REG_LINE_STAT: rd_byte = {6'h00, line_disconnect_detected_r, 1'b0};
				REG_TEST_STAT: rd_byte = {7'h00, loop_pattern_detected_r};
				REG_PDATA_HIGH: rd_byte = param_data_high_r;
				REG_PDATA_LOW: rd_byte = param_data_low_r;
				REG_PADDR_LOW: rd_byte = param_addr_low_r;
				REG_PADDR_HIGH: rd_byte = param_addr_high_r;
				REG_PACCESS: rd_byte = paccess_r;
				default: rd_byte = RESET_BYTE;
			endcase
		end
	end

	// Bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
			begin
				wb_dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Plain control registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phase_det_r <= RESET_BYTE;
			async_fmt_r <= RESET_BYTE;
			loop_sig_r <= RESET_BYTE;
			param_addr_low_r <= RESET_BYTE;
			param_addr_high_r <= RESET_BYTE;
		end
		else if (wb_wr && wb_adr_i[7] == 1'b0)
		begin
			unique case (reg_idx)
				REG_PHASE_DET: phase_det_r <= wb_dat_i[7:0];
				REG_ASYNC_FMT: async_fmt_r <= wb_dat_i[7:0];
				REG_LOOP_SIG: loop_sig_r <= wb_dat_i[7:0];
				REG_PADDR_LOW: param_addr_low_r <= wb_dat_i[7:0];
				REG_PADDR_HIGH: param_addr_high_r <= wb_dat_i[7:0] & PADDR_HIGH_MASK;
				default: ;
			endcase
		end
	end

	// Detector enables and word size decoded into flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			loop_prep_detector_enable_o <= 1'b0;
			loop_ack_detector_enable_o <= 1'b0;
			loop_term_detector_enable_o <= 1'b0;
			char_bits_o <= CHAR_BITS_MIN;
		end
		else
		begin
			loop_prep_detector_enable_o <= phase_det_r[BIT_PREP_DET_EN];
			loop_ack_detector_enable_o <= phase_det_r[BIT_ACK_DET_EN];
			loop_term_detector_enable_o <= phase_det_r[BIT_TERM_DET_EN];
			char_bits_o <= CHAR_BITS_MIN + {2'b00, async_fmt_r[1:0]};
		end
	end

	// Status bits follow their causes; read-only from the bus
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			line_disconnect_detected_r <= 1'b0;
			loop_pattern_detected_r <= 1'b0;
		end
		else
		begin
			line_disconnect_detected_r <= line_disconnect_i & own_signal_lock_i;
			// A detector that is off cannot report
			loop_pattern_detected_r <= (prep_pattern_seen_i & phase_det_r[BIT_PREP_DET_EN])
				| (ack_pattern_seen_i & phase_det_r[BIT_ACK_DET_EN])
				| (term_pattern_seen_i & phase_det_r[BIT_TERM_DET_EN]);
		end
	end

	// Sample period strobe standing in for the DSP poll
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_cnt_r <= 14'd0;
			sample_tick_r <= 1'b0;
		end
		else if (sample_cnt_r == 14'(SAMPLE_PERIOD - 1))
		begin
			sample_cnt_r <= 14'd0;
			sample_tick_r <= 1'b1;
		end
		else
		begin
			sample_cnt_r <= sample_cnt_r + 14'd1;
			sample_tick_r <= 1'b0;
		end
	end

	// RAM port; read data lands one cycle after the poll
	always_ff @(posedge clk_i)
	begin
		ram_q_r <= ram_mem[ram_addr[RAM_ADDR_W - 1:0]];
		if (access_go && paccess_r[BIT_ACC_WRITE] && !diag_word)
		begin
			if (paccess_r[BIT_ACC_WORD])
			begin
				ram_mem[ram_addr[RAM_ADDR_W - 1:0]] <= {param_data_high_r, param_data_low_r};
			end
			else if (paccess_r[BIT_ACC_HIGH])
			begin
				ram_mem[ram_addr[RAM_ADDR_W - 1:0]][15:8] <= param_data_high_r;
			end
			else
			begin
				ram_mem[ram_addr[RAM_ADDR_W - 1:0]][7:0] <= param_data_low_r;
			end
		end
	end

	// Pending read marks the completion cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			read_pend_r <= 1'b0;
		end
		else
		begin
			read_pend_r <= access_go & ~paccess_r[BIT_ACC_WRITE];
		end
	end

	// Data registers: host writes, or RAM reads on completion
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			param_data_high_r <= RESET_BYTE;
			param_data_low_r <= RESET_BYTE;
		end
		else if (read_pend_r)
		begin
			param_data_low_r <= ram_q_r[7:0];
			// Byte-only parameters leave the high register alone
			if (paccess_r[BIT_ACC_WORD] || paccess_r[BIT_ACC_HIGH] || diag_word)
			begin
				param_data_high_r <= ram_q_r[15:8];
			end
		end
		else if (wb_wr && wb_adr_i[7] == 1'b0)
		begin
			if (reg_idx == REG_PDATA_HIGH)
			begin
				param_data_high_r <= wb_dat_i[7:0];
			end
			if (reg_idx == REG_PDATA_LOW)
			begin
				param_data_low_r <= wb_dat_i[7:0];
			end
		end
	end

	// Access control; a host write in the completion cycle wins so a new request survives
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			paccess_r <= RESET_BYTE;
		end
		else if (wb_wr && wb_adr_i[7] == 1'b0 && reg_idx == REG_PACCESS)
		begin
			paccess_r <= wb_dat_i[7:0] & PACCESS_MASK;
		end
		else if ((access_go && paccess_r[BIT_ACC_WRITE]) || read_pend_r)
		begin
			paccess_r[BIT_ACC_REQ] <= 1'b0;
		end
	end

	// Rising control bits launch a pattern; termination outranks acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			loop_sig_prev_r <= RESET_BYTE;
		end
		else if (tx_state_r == TX_IDLE)
		begin
			loop_sig_prev_r <= loop_sig_r;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_state_r <= TX_IDLE;
			tx_cnt_r <= 14'd0;
			tx_din_r <= 1'b0;
		end
		else
		begin
			unique case (tx_state_r)
				TX_IDLE:
				begin
					if (loop_rise[BIT_TERM_SEND])
					begin
						tx_state_r <= TX_SCRAMBLED;
						tx_cnt_r <= TERM_BITS;
						tx_din_r <= 1'b1;
					end
					else if (loop_rise[BIT_ACK_SEND])
					begin
						tx_state_r <= TX_SCRAMBLED;
						tx_cnt_r <= ACK_BITS;
						tx_din_r <= 1'b1;
					end
					else if (loop_rise[BIT_PREP_SEND])
					begin
						tx_state_r <= TX_SCRAMBLED;
						tx_cnt_r <= PREP_BITS;
						tx_din_r <= 1'b0;
					end
				end
				TX_SCRAMBLED:
				begin
					if (tx_bit_tick_i)
					begin
						if (tx_cnt_r != 14'd1)
						begin
							tx_cnt_r <= tx_cnt_r - 14'd1;
						end
						else if (loop_sig_prev_r[BIT_TERM_SEND] && tx_din_r)
						begin
							tx_state_r <= TX_TAIL;
							tx_cnt_r <= TERM_TAIL_BITS;
						end
						else
						begin
							tx_state_r <= TX_IDLE;
						end
					end
				end
				TX_TAIL:
				begin
					if (tx_bit_tick_i)
					begin
						tx_cnt_r <= tx_cnt_r - 14'd1;
						if (tx_cnt_r == 14'd1)
						begin
							tx_state_r <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Self-synchronising scrambler, taps at delays four and seven
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scr_r <= SCRAMBLER_SEED;
			loop_tx_bit_o <= 1'b1;
			loop_tx_active_o <= 1'b0;
		end
		else
		begin
			loop_tx_active_o <= tx_state_r != TX_IDLE;
			if (tx_state_r == TX_IDLE)
			begin
				scr_r <= SCRAMBLER_SEED;
				loop_tx_bit_o <= 1'b1;
			end
			else if (tx_bit_tick_i && tx_state_r == TX_SCRAMBLED)
			begin
				scr_r <= {scr_r[5:0], scr_fb};
				loop_tx_bit_o <= scr_fb;
			end
			else if (tx_bit_tick_i)
			begin
				loop_tx_bit_o <= 1'b1;
			end
		end
	end

endmodule

// ===== testbench/hidra_top_assertions.sv
// Checker on hidra_top ports: bus answer, register copies, pattern bit timing.
// Assumes classic single Wishbone cycles with sel[0] set on writes.
`timescale 1ns/1ps
module hidra_top_assertions
	import hidra_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic tx_bit_tick_i,
	input wire logic loop_tx_bit_o,
	input wire logic loop_tx_active_o,
	input wire logic loop_prep_detector_enable_o,
	input wire logic loop_ack_detector_enable_o,
	input wire logic loop_term_detector_enable_o,
	input wire logic [3:0] char_bits_o
);
	logic req;
	logic wr;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && !wb_adr_i[7];
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ack_next;
		req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("long ack");
	property p_ack_idle;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
	property p_upper;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper data set");
	property p_unmapped;
		req && !wb_we_i && wb_adr_i[7] |=> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_char;
		wr && wb_adr_i[6:2] == REG_ASYNC_FMT |-> ##2
			char_bits_o == CHAR_BITS_MIN + {2'b00, $past(wb_dat_i[1:0], 2)};
	endproperty
	a_char: assert property (p_char) else $error("char length");
	property p_det;
		wr && wb_adr_i[6:2] == REG_PHASE_DET |-> ##2 {loop_term_detector_enable_o,
			loop_ack_detector_enable_o, loop_prep_detector_enable_o} == $past(wb_dat_i[2:0], 2);
	endproperty
	a_det: assert property (p_det) else $error("detector enables");
	// Return to the idle level after a frame is not tied to a tick
	property p_bit_hold;
		!$past(tx_bit_tick_i) && loop_tx_active_o && !$past(rst_i) |-> $stable(loop_tx_bit_o);
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("bit off tick");
endmodule
bind hidra_top hidra_top_assertions i_hidra_top_assertions (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_bit_tick_i(tx_bit_tick_i),
	.loop_tx_bit_o(loop_tx_bit_o), .loop_tx_active_o(loop_tx_active_o),
	.loop_prep_detector_enable_o(loop_prep_detector_enable_o),
	.loop_ack_detector_enable_o(loop_ack_detector_enable_o),
	.loop_term_detector_enable_o(loop_term_detector_enable_o), .char_bits_o(char_bits_o));

// ===== testbench/hidra_host.sv
// Host model: classic Wishbone master doing single register cycles.
// Assumes the bench top owns fails and give_verdict for a hung bus.
`timescale 1ns/1ps
module hidra_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o
);
	initial
	begin
		cyc_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		we_o <= w;
		adr_o <= {i, 2'b00};
		dat_o <= {24'h0, d};
		@(posedge clk_i);
		for (n = 0; n < 20 && ack_i !== 1'b1; n++)
			@(posedge clk_i);
		if (n == 20)
		begin
			host_interface_memory_dsp_ram_access_bench.fails++;
			host_interface_memory_dsp_ram_access_bench.give_verdict();
		end
		q = dat_i[7:0];
		cyc_o <= 1'b0;
		we_o <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, i, d, q);
	endtask
	task automatic rd(input logic [5:0] i, output logic [7:0] q);
		xfer(1'b0, i, 8'h00, q);
	endtask
	// Shared control bits change only by read-modify-write
	task automatic rmw(input logic [5:0] i, input logic [7:0] m, input logic [7:0] v);
		logic [7:0] q;
		rd(i, q);
		wr(i, (q & ~m) | (v & m));
	endtask
endmodule

// ===== testbench/host_interface_memory_dsp_ram_access_bench.sv
// Bench for hidra_top: registers, parameter RAM window, loopback pattern lengths.
// Assumes hidra_host drives the bus; sample period shortened to 50 clocks.
`timescale 1ns/1ps
module host_interface_memory_dsp_ram_access_bench
	import hidra_pkg::*;
;
	logic clk, rst, disc, lock, tick, tick_q, cyc, we, ack, en_p, en_a, en_t, act, bit_o;
	logic pdin, eb;
	logic [6:0] ms;
	logic [2:0] seen;
	logic [3:0] cb;
	logic [7:0] adr, q;
	logic [31:0] dw, dr, rnd;
	int fails, samples_checked, cnt, base, n, bad, plen;
	hidra_top #(.SAMPLE_PERIOD(50)) i_hidra_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .line_disconnect_i(disc), .own_signal_lock_i(lock),
		.prep_pattern_seen_i(seen[0]), .ack_pattern_seen_i(seen[1]),
		.term_pattern_seen_i(seen[2]), .tx_bit_tick_i(tick), .loop_tx_bit_o(bit_o),
		.loop_tx_active_o(act), .loop_prep_detector_enable_o(en_p),
		.loop_ack_detector_enable_o(en_a), .loop_term_detector_enable_o(en_t), .char_bits_o(cb));
	hidra_host i_hidra_host (.clk_i(clk), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .we_o(we),
		.adr_o(adr), .dat_o(dw));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Scrambler 1+x^-4+x^-7: output is input xor delays four and seven
	function automatic logic scr_bit(input logic [6:0] s, input logic d);
		return d ^ s[3] ^ s[6];
	endfunction
	// Active lags state by a clock, so ticks and their bits are taken one clock late
	always @(posedge clk)
	begin
		tick <= ~tick & ~rst;
		tick_q <= tick;
		if (act !== 1'b1)
			ms = SCRAMBLER_SEED;
		else if (tick_q)
		begin
			eb = (cnt - base < plen) ? scr_bit(ms, pdin) : 1'b1;
			ms = {ms[5:0], eb};
			bad += int'(bit_o !== eb);
			cnt++;
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic [7:0] d);
		i_hidra_host.wr({1'b0, r}, d);
	endtask
	task automatic rd(input logic [4:0] r);
		i_hidra_host.rd({1'b0, r}, q);
	endtask
	task automatic poll();
		for (n = 0; n < 40; n++)
		begin
			rd(REG_PACCESS);
			if (q[BIT_ACC_REQ] === 1'b0)
				break;
		end
		chk("request", 16'(q[BIT_ACC_REQ]), 16'h0);
		if (n == 40)
			give_verdict();
	endtask
	task automatic wait_act(input logic v, input int lim);
		for (n = 0; n < lim && act !== v; n++)
			@(posedge clk);
		if (n == lim)
		begin
			fails++;
			give_verdict();
		end
	endtask
	initial
	begin
		rst = 1'b1;
		{disc, lock, seen} = 5'h00;
		{fails, samples_checked} = 64'h0;
		rnd = 32'h6C3B31CA;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk("char_rst", 16'(cb), 16'h5);
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			wr(REG_ASYNC_FMT, {rnd[7:2], 2'(i)});
			repeat (2) @(posedge clk);
			chk("char_bits", 16'(cb), 16'(i + 5));
			rd(REG_ASYNC_FMT);
			chk("fmt", 16'(q), 16'({rnd[7:2], 2'(i)}));
		end
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			wr(REG_PHASE_DET, {5'h0, rnd[2:0]});
			{seen, disc, lock} <= rnd[7:3];
			repeat (2) @(posedge clk);
			chk("det_en", 16'({en_t, en_a, en_p}), 16'(rnd[2:0]));
			wr(REG_LINE_STAT, 8'hFF);
			rd(REG_LINE_STAT);
			chk("disc", 16'(q & 8'h02), 16'({rnd[4] & rnd[3], 1'b0}));
			rd(REG_TEST_STAT);
			chk("pattern", 16'(q & 8'h01), 16'(|(rnd[7:5] & rnd[2:0])));
		end
		i_hidra_host.rd(6'h20, q);
		chk("unmapped", 16'(q), 16'h0);
		// Top word below the read-only diagnostic area; address set before request
		wr(REG_PADDR_LOW, 8'hFF);
		wr(REG_PADDR_HIGH, 8'h0E);
		wr(REG_PDATA_HIGH, rnd[15:8]);
		wr(REG_PDATA_LOW, rnd[7:0]);
		wr(REG_PACCESS, 8'h07);
		poll();
		wr(REG_PDATA_HIGH, 8'h00);
		wr(REG_PDATA_LOW, 8'h00);
		wr(REG_PACCESS, 8'h05);
		poll();
		rd(REG_PDATA_HIGH);
		chk("word_hi", 16'(q), 16'(rnd[15:8]));
		rd(REG_PDATA_LOW);
		chk("word_lo", 16'(q), 16'(rnd[7:0]));
		wr(REG_PDATA_LOW, rnd[23:16]);
		wr(REG_PACCESS, 8'h03);
		poll();
		wr(REG_PDATA_HIGH, 8'hA5);
		wr(REG_PACCESS, 8'h01);
		poll();
		rd(REG_PDATA_HIGH);
		chk("byte_hi_kept", 16'(q), 16'hA5);
		wr(REG_PDATA_HIGH, rnd[31:24]);
		wr(REG_PACCESS, 8'h0B);
		poll();
		wr(REG_PACCESS, 8'h09);
		poll();
		rd(REG_PDATA_HIGH);
		chk("hi_byte", 16'(q), 16'(rnd[31:24]));
		rd(REG_PDATA_LOW);
		chk("lo_byte", 16'(q), 16'(rnd[23:16]));
		// Writes into the diagnostic area are dropped but still complete
		wr(REG_PADDR_HIGH, {4'h0, DIAG_BASE_DEF[11:8]});
		wr(REG_PADDR_LOW, DIAG_BASE_DEF[7:0]);
		wr(REG_PDATA_LOW, 8'h5A);
		wr(REG_PACCESS, 8'h07);
		poll();
		wr(REG_PACCESS, 8'h05);
		poll();
		rd(REG_PDATA_LOW);
		chk("diag_ro", 16'(q === 8'h5A), 16'h0);
		// No modulation modes exist here, so loopback controls are legal
		for (int k = 0; k < 3; k++)
		begin
			base = cnt;
			pdin = k != 0;
			plen = k == 0 ? int'(PREP_BITS) : k == 1 ? int'(ACK_BITS) : int'(TERM_BITS);
			i_hidra_host.rmw({1'b0, REG_LOOP_SIG}, 8'h1C, 8'(8'h04 << k));
			wait_act(1'b1, 200);
			wait_act(1'b0, 20000);
			chk("tx_bits", 16'(cnt - base), k == 0 ? 16'(PREP_BITS) : k == 1 ? 16'(ACK_BITS) :
				16'(TERM_BITS + TERM_TAIL_BITS));
			chk("tx_pattern", 16'(bad), 16'h0);
			i_hidra_host.rmw({1'b0, REG_LOOP_SIG}, 8'h1C, 8'h00);
		end
		give_verdict();
	end
endmodule
